/* File: rtl/omc_operating_mode_controller.sv */
// Operating mode controller: mode sequencing and clock gating
`timescale 1ns/1ns
`include "omc_consts.svh"
module omc_operating_mode_controller
  import omc_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic                        doze_req,
  input  wire logic                        halt_req,
  input  wire logic                        stop_req,
  input  wire logic                        dual_clock_req,
  input  wire logic                        system_clock_select_bit,
  input  wire logic                        fast_osc_enable_bit,
  input  wire logic [`OMC_IRQ_W-1:0]       irq_latch,
  input  wire logic [`OMC_IRQ_W-1:0]       interrupt_enable_register,
  input  wire logic                        master_interrupt_enable,
  input  wire logic                        time_base_irq_enable,
  input  wire logic                        time_base_enable_bit,
  input  wire logic                        time_base_src,
  input  wire logic                        stop_pin_release,
  input  wire logic                        key_wakeup_release,
  input  wire logic                        voltage_det_release,
  input  wire logic [`OMC_WARM_CMP_W-1:0]  warmup_compare_value,
  output logic [10:0]                      mode,
  output logic                             main_clk_from_low,
  output logic                             main_clk_en,
  output logic                             cpu_clk_en,
  output logic                             wdt_clk_en,
  output logic                             periph_clk_en,
  output logic                             time_base_clk_en,
  output logic                             prescaler_run,
  output logic                             fast_osc_run,
  output logic                             low_osc_run,
  output logic                             low_pins_are_port,
  output logic                             time_base_interrupt,
  output logic                             resume_next_insn,
  output logic                             service_irq
);

  omc_state_t st_reg;
  omc_state_t st_next;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic is_dual(input omc_mode_t m);
    is_dual = (m == OMC_DC_FAST) || (m == OMC_DC_DOZE) ||
              (m == OMC_SLOW_OFF) || (m == OMC_SLOW_ON) ||
              (m == OMC_SLOW_DOZE) || (m == OMC_SLOW_DEEP);
  endfunction : is_dual

  function automatic logic is_slow(input omc_mode_t m);
    is_slow = (m == OMC_SLOW_OFF) || (m == OMC_SLOW_ON) ||
              (m == OMC_SLOW_DOZE) || (m == OMC_SLOW_DEEP);
  endfunction : is_slow

  // Base enables {cpu, watchdog, peripherals, time base} per mode
  function automatic logic [3:0] gate_mask(input omc_mode_t m);
    case (m)
      OMC_SC_RUN:    gate_mask = 4'hF;
      OMC_DC_FAST:   gate_mask = 4'hF;
      OMC_SLOW_ON:   gate_mask = 4'hF;
      OMC_SLOW_OFF:  gate_mask = 4'hF;
      OMC_SC_DOZE:   gate_mask = 4'h3;
      OMC_DC_DOZE:   gate_mask = 4'h3;
      OMC_SLOW_DOZE: gate_mask = 4'h3;
      OMC_SC_DEEP:   gate_mask = 4'h1;
      OMC_SLOW_DEEP: gate_mask = 4'h1;
      default:       gate_mask = 4'h0;
    endcase
  endfunction : gate_mask

  // Prescaler and dividers held in slow runs, slow doze, stop, warm-up
  function automatic logic presc_held(input omc_mode_t m);
    case (m)
      OMC_SLOW_OFF:  presc_held = 1'b1;
      OMC_SLOW_ON:   presc_held = 1'b1;
      OMC_SLOW_DOZE: presc_held = 1'b1;
      OMC_STOP:      presc_held = 1'b1;
      OMC_WARM:      presc_held = 1'b1;
      default:       presc_held = 1'b0;
    endcase
  endfunction : presc_held

  // Pins stay with the oscillator while a dual mode is to be resumed
  function automatic logic owns_low_pins(input omc_mode_t m,
                                         input omc_mode_t r);
    owns_low_pins = is_dual(m) ||
                    (((m == OMC_STOP) || (m == OMC_WARM)) && is_dual(r));
  endfunction : owns_low_pins

  logic any_irq;
  logic tbt_fall;
  logic stop_release;
  logic warm_done;

  assign any_irq      = |(irq_latch & interrupt_enable_register);
  assign tbt_fall     = st_reg.tbt_src_d & ~time_base_src;
  assign stop_release = stop_pin_release | key_wakeup_release |
                        voltage_det_release;
  assign warm_done    = (st_reg.warm_cnt[`OMC_WARM_STAGES-1:
                         `OMC_WARM_CMP_LSB] ==
                         warmup_compare_value);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.tbt_src_d     = time_base_src;
    st_next.tbt_latch_set = 1'b0;
    st_next.slow_div      = st_reg.slow_div +
                            `OMC_SLOW_DIV_W'(1);
    case (st_reg.mode)
      OMC_SC_RUN: begin
        if (stop_req) begin
          st_next.resume = OMC_SC_RUN;
          st_next.mode   = OMC_STOP;
        end else if (doze_req) begin
          st_next.mode = OMC_SC_DOZE;
        end else if (halt_req) begin
          st_next.mode         = OMC_SC_DEEP;
          st_next.tbt_at_entry = time_base_enable_bit;
        end else if (dual_clock_req) begin
          st_next.mode = OMC_DC_FAST;
        end
      end
      OMC_DC_FAST: begin
        if (stop_req) begin
          st_next.resume = OMC_DC_FAST;
          st_next.mode   = OMC_STOP;
        end else if (doze_req) begin
          st_next.mode = OMC_DC_DOZE;
        end else if (system_clock_select_bit) begin
          st_next.mode = OMC_SLOW_ON;
        end else if (!dual_clock_req) begin
          st_next.mode = OMC_SC_RUN;
        end
      end
      OMC_SLOW_ON: begin
        if (stop_req) begin
          st_next.resume = OMC_SLOW_ON;
          st_next.mode   = OMC_STOP;
        end else if (!system_clock_select_bit) begin
          st_next.mode = OMC_DC_FAST;
        end else if (!fast_osc_enable_bit) begin
          st_next.mode = OMC_SLOW_OFF;
        end
      end
      OMC_SLOW_OFF: begin
        if (stop_req) begin
          st_next.resume = OMC_SLOW_OFF;
          st_next.mode   = OMC_STOP;
        end else if (doze_req) begin
          st_next.mode = OMC_SLOW_DOZE;
        end else if (halt_req) begin
          st_next.mode         = OMC_SLOW_DEEP;
          st_next.tbt_at_entry = time_base_enable_bit;
        end else if (fast_osc_enable_bit) begin
          st_next.mode = OMC_SLOW_ON;
        end
      end
      OMC_SC_DOZE, OMC_DC_DOZE, OMC_SLOW_DOZE: begin
        if (any_irq) begin
          st_next.resume_next_insn = ~master_interrupt_enable;
          st_next.service_irq      = master_interrupt_enable;
          if (st_reg.mode == OMC_SC_DOZE)
            st_next.mode = OMC_SC_RUN;
          else if (st_reg.mode == OMC_DC_DOZE)
            st_next.mode = OMC_DC_FAST;
          else
            st_next.mode = OMC_SLOW_OFF;
        end
      end
      OMC_SC_DEEP, OMC_SLOW_DEEP: begin
        if (tbt_fall) begin
          st_next.mode = (st_reg.mode == OMC_SC_DEEP) ?
                         OMC_SC_RUN : OMC_SLOW_OFF;
          st_next.tbt_latch_set = st_reg.tbt_at_entry;
          st_next.service_irq   = st_reg.tbt_at_entry &
                                  master_interrupt_enable &
                                  time_base_irq_enable;
          st_next.resume_next_insn = ~(st_reg.tbt_at_entry &
                                  master_interrupt_enable &
                                  time_base_irq_enable);
        end
      end
      OMC_STOP: begin
        st_next.slow_div = '0;
        if (stop_release) begin
          st_next.mode     = OMC_WARM;
          st_next.warm_cnt = '0;
        end
      end
      OMC_WARM: begin
        st_next.slow_div = '0;
        if (warm_done) begin
          st_next.mode             = st_reg.resume;
          st_next.resume_next_insn = 1'b1;
          st_next.service_irq      = 1'b0;
        end else begin
          st_next.warm_cnt = st_reg.warm_cnt +
                             `OMC_WARM_STAGES'(1);
        end
      end
      default: begin
        st_next.mode = OMC_SC_RUN;
      end
    endcase
    // Release indications clear in the first cycle the mode stays unchanged; a back-to-back mode change carries them over
    if (st_next.mode == st_reg.mode) begin
      st_next.resume_next_insn = 1'b0;
      st_next.service_irq      = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg.mode             <= OMC_SC_RUN;
      st_reg.resume           <= OMC_SC_RUN;
      st_reg.tbt_at_entry     <= 1'b0;
      st_reg.tbt_src_d        <= 1'b0;
      st_reg.warm_cnt         <= '0;
      st_reg.slow_div         <= '0;
      st_reg.tbt_latch_set    <= 1'b0;
      st_reg.resume_next_insn <= 1'b0;
      st_reg.service_irq      <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Clock gating decode
  // ---------------------------------------------------------------
  omc_mode_t  m;
  logic       slow;
  logic [3:0] gate;
  assign m    = st_reg.mode;
  assign slow = is_slow(m);
  assign gate = gate_mask(m);

  // ---------------------------------------------------------------
  // Clock enables
  // ---------------------------------------------------------------
  assign mode              = st_reg.mode;
  assign main_clk_from_low = slow;
  // Quarter low clock pulse in slow modes, gear clock otherwise
  assign main_clk_en       = slow ? (st_reg.slow_div == '0)
                                  : 1'b1;
  assign cpu_clk_en        = gate[3] & main_clk_en;
  assign wdt_clk_en        = gate[2] & main_clk_en;
  assign periph_clk_en     = gate[1] & main_clk_en;
  assign time_base_clk_en  = gate[0] & main_clk_en;
  assign prescaler_run     = ~presc_held(m);

  // ---------------------------------------------------------------
  // Oscillators and pins
  // ---------------------------------------------------------------
  assign fast_osc_run      = ~((m == OMC_SLOW_OFF) | (m == OMC_SLOW_DOZE) |
                             (m == OMC_SLOW_DEEP) | (m == OMC_STOP));
  assign low_osc_run       = is_dual(m) | ((m == OMC_WARM) &&
                             is_dual(st_reg.resume));
  assign low_pins_are_port = ~owns_low_pins(m, st_reg.resume);

  // ---------------------------------------------------------------
  // Release indications
  // ---------------------------------------------------------------
  assign time_base_interrupt = st_reg.tbt_latch_set;
  assign resume_next_insn    = st_reg.resume_next_insn;
  assign service_irq         = st_reg.service_irq;

endmodule : omc_operating_mode_controller

/* File: rtl/omc_consts.svh */
// Timing counts and field layouts for the operating mode controller
`ifndef OMC_CONSTS_SVH
`define OMC_CONSTS_SVH
`define OMC_WARM_STAGES   14
`define OMC_WARM_CMP_W    8
`define OMC_WARM_CMP_LSB  6
`define OMC_WARM_RESET    8'h66
`define OMC_SLOW_DIV      4
`define OMC_SLOW_DIV_W    2
`define OMC_IRQ_W         8
`endif

/* File: rtl/omc_pkg.sv */
// Types for the operating mode controller
`include "omc_consts.svh"
package omc_pkg;
  typedef enum logic [10:0] {
    OMC_SC_RUN    = 11'h001,
    OMC_SC_DOZE   = 11'h002,
    OMC_SC_DEEP   = 11'h004,
    OMC_DC_FAST   = 11'h008,
    OMC_DC_DOZE   = 11'h010,
    OMC_SLOW_OFF  = 11'h020,
    OMC_SLOW_ON   = 11'h040,
    OMC_SLOW_DOZE = 11'h080,
    OMC_SLOW_DEEP = 11'h100,
    OMC_STOP      = 11'h200,
    OMC_WARM      = 11'h400
  } omc_mode_t;

  typedef struct packed {
    omc_mode_t                         mode;
    omc_mode_t                         resume;
    logic                              tbt_at_entry;
    logic                              tbt_src_d;
    logic [`OMC_WARM_STAGES-1:0]       warm_cnt;
    logic [`OMC_SLOW_DIV_W-1:0]        slow_div;
    logic                              tbt_latch_set;
    logic                              resume_next_insn;
    logic                              service_irq;
  } omc_state_t;
endpackage : omc_pkg

/* File: testbench/omc_mode_properties.sv */
// Port-level checks for the operating mode controller
`timescale 1ns/1ns
`include "omc_consts.svh"
module omc_mode_properties (
  input wire logic                  clk,
  input wire logic                  arst_n,
  input wire logic                  doze_req,
  input wire logic                  halt_req,
  input wire logic                  stop_req,
  input wire logic [`OMC_IRQ_W-1:0] irq_latch,
  input wire logic [`OMC_IRQ_W-1:0] interrupt_enable_register,
  input wire logic                  master_interrupt_enable,
  input wire logic                  time_base_src,
  input wire logic [10:0]           mode,
  input wire logic                  main_clk_from_low,
  input wire logic                  main_clk_en,
  input wire logic                  cpu_clk_en,
  input wire logic                  wdt_clk_en,
  input wire logic                  periph_clk_en,
  input wire logic                  low_pins_are_port,
  input wire logic                  time_base_interrupt,
  input wire logic                  resume_next_insn,
  input wire logic                  service_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // --------------------------------------------------------------
  // Mode sequences and their checks
  // --------------------------------------------------------------
  sequence s_tb_fall;
    $past(time_base_src) && !time_base_src;
  endsequence
  sequence s_slow_tick;
    mode == 11'h020 && main_clk_en ##1 mode == 11'h020;
  endsequence
  a_doze_entry: assert property (
    mode == 11'h001 && doze_req && !stop_req |=> mode == 11'h002)
    else $error("doze request not taken");
  a_doze_gates: assert property (
    mode == 11'h002 |-> !cpu_clk_en && !wdt_clk_en && periph_clk_en)
    else $error("doze clock gating wrong");
  a_doze_release: assert property (
    mode == 11'h002 && |(irq_latch & interrupt_enable_register) && !stop_req
    |=> mode == 11'h001 && service_irq == $past(master_interrupt_enable)
    && resume_next_insn != $past(master_interrupt_enable))
    else $error("doze release wrong");
  a_halt_entry: assert property (
    mode == 11'h001 && halt_req && !stop_req && !doze_req
    |=> mode == 11'h004) else $error("deep doze not entered");
  a_deep_gates: assert property (
    mode inside {11'h004, 11'h100}
    |-> !cpu_clk_en && !wdt_clk_en && !periph_clk_en)
    else $error("deep mode clocks running");
  a_deep_release: assert property (
    mode == 11'h004 && !stop_req ##0 s_tb_fall |=> mode == 11'h001)
    else $error("deep doze not released");
  a_tb_pulse: assert property (
    time_base_interrupt |-> (mode == 11'h001 && $past(mode) == 11'h004)
    || (mode == 11'h020 && $past(mode) == 11'h100))
    else $error("time base latch set outside deep release");
  a_single_pins: assert property (
    mode inside {11'h001, 11'h002, 11'h004}
    |-> low_pins_are_port && !main_clk_from_low && main_clk_en)
    else $error("single clock mode pins or clock wrong");
  a_dual_pins: assert property (
    mode inside {11'h008, 11'h010, 11'h020, 11'h040, 11'h080, 11'h100}
    |-> !low_pins_are_port) else $error("dual mode pins released");
  a_slow_quarter: assert property (
    s_slow_tick |-> !main_clk_en) else $error("slow clock not divided");
endmodule : omc_mode_properties
bind omc_operating_mode_controller omc_mode_properties u_props (.*);

/* File: testbench/omc_time_src_model.sv */
// Time base source clock model: free-running divided clock
`timescale 1ns/1ns
module omc_time_src_model #(
  parameter int HALF = 8
) (
  input  wire logic clk,
  input  wire logic arst_n,
  output logic      time_base_src
);
  int cnt;
  always @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      time_base_src <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      time_base_src <= ~time_base_src;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : omc_time_src_model

/* File: testbench/omc_operating_mode_controller_tb.sv */
// Self-checking bench for the operating mode controller
`timescale 1ns/1ns
`include "omc_consts.svh"
module omc_operating_mode_controller_tb;
  logic clk = 1'b0, arst_n = 1'b0;
  logic doze_req, halt_req, stop_req, dual_clock_req;
  logic system_clock_select_bit, fast_osc_enable_bit;
  logic [`OMC_IRQ_W-1:0] irq_latch, interrupt_enable_register;
  logic master_interrupt_enable, time_base_irq_enable, time_base_enable_bit;
  logic time_base_src, stop_pin_release, key_wakeup_release;
  logic voltage_det_release;
  logic [`OMC_WARM_CMP_W-1:0] warmup_compare_value;
  logic [10:0] mode;
  logic main_clk_from_low, main_clk_en, cpu_clk_en, wdt_clk_en;
  logic periph_clk_en, time_base_clk_en, prescaler_run, fast_osc_run;
  logic low_osc_run, low_pins_are_port, time_base_interrupt;
  logic resume_next_insn, service_irq;
  int miscompares = 0, check_count = 0, i, k;
  always #25 clk = ~clk;
  omc_operating_mode_controller DUT (.*);
  omc_time_src_model #(.HALF(8)) u_tsrc (.clk, .arst_n, .time_base_src);
  task automatic chk(input string what, input logic [11:0] seen,
                     input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic pulse(ref logic r);
    r = 1'b1;
    cyc(1);
    r = 1'b0;
  endtask : pulse
  task automatic wait_tbi();
    for (i = 0; i < 40 && time_base_interrupt !== 1'b1; i++) cyc(1);
    chk("tb irq", time_base_interrupt, 1'b1);
    chk("tb svc", {service_irq, resume_next_insn}, 2'h2);
  endtask : wait_tbi
  task test_done();
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    {doze_req, halt_req, stop_req, dual_clock_req} = 4'h0;
    {system_clock_select_bit, fast_osc_enable_bit} = 2'h0;
    {irq_latch, interrupt_enable_register} = 16'h0000;
    {master_interrupt_enable, time_base_irq_enable} = 2'h3;
    time_base_enable_bit = 1'b1;
    {stop_pin_release, key_wakeup_release, voltage_det_release} = 3'h0;
    warmup_compare_value = 8'h02;
    cyc(10);
    arst_n = 1'b1;
    chk("reset mode", mode, 11'h001);
    chk("pins", {low_pins_are_port, main_clk_from_low}, 2'h2);
    chk("low osc off", low_osc_run, 1'b0);
    for (k = 0; k < 2; k++) begin
      master_interrupt_enable = k[0];
      pulse(doze_req);
      chk("doze", {cpu_clk_en, wdt_clk_en, periph_clk_en}, 3'h1);
      irq_latch = 8'h10;
      cyc(1);
      chk("masked", mode, 11'h002);
      interrupt_enable_register = 8'h10;
      cyc(1);
      chk("wake", mode, 11'h001);
      chk("svc", {service_irq, resume_next_insn}, k ? 2'h2 : 2'h1);
      {irq_latch, interrupt_enable_register} = 16'h0000;
    end
    pulse(halt_req);
    chk("deep", {mode[2], cpu_clk_en, periph_clk_en}, 3'h4);
    chk("deep tb", time_base_clk_en, 1'b1);
    wait_tbi();
    chk("deep end", mode, 11'h001);
    time_base_enable_bit = 1'b0;
    pulse(halt_req);
    for (i = 0; i < 40 && mode === 11'h004; i++) cyc(1);
    chk("deep end2", mode, 11'h001);
    chk("no tb irq", time_base_interrupt, 1'b0);
    chk("deep resume", {service_irq, resume_next_insn}, 2'h1);
    time_base_enable_bit = 1'b1;
    system_clock_select_bit = 1'b1;
    cyc(2);
    chk("no switch", mode, 11'h001);
    system_clock_select_bit = 1'b0;
    dual_clock_req = 1'b1;
    fast_osc_enable_bit = 1'b1;
    cyc(1);
    chk("dual", {mode[3], low_pins_are_port}, 2'h2);
    chk("low osc", low_osc_run, 1'b1);
    system_clock_select_bit = 1'b1;
    cyc(1);
    chk("slow on", mode, 11'h040);
    chk("presc", {main_clk_from_low, prescaler_run}, 2'h2);
    fast_osc_enable_bit = 1'b0;
    cyc(1);
    chk("slow off", {mode[5], fast_osc_run}, 2'h2);
    pulse(doze_req);
    chk("slow doze", {mode[7], cpu_clk_en, fast_osc_run}, 3'h4);
    irq_latch = 8'h01;
    interrupt_enable_register = 8'h01;
    cyc(1);
    chk("slow wake", mode, 11'h020);
    {irq_latch, interrupt_enable_register} = 16'h0000;
    pulse(halt_req);
    chk("sleep", {mode[8], periph_clk_en, fast_osc_run}, 3'h4);
    wait_tbi();
    chk("sleep end", mode, 11'h020);
    fast_osc_enable_bit = 1'b1;
    cyc(1);
    system_clock_select_bit = 1'b0;
    cyc(1);
    pulse(doze_req);
    chk("dual doze", {mode[4], cpu_clk_en, periph_clk_en}, 3'h5);
    irq_latch = 8'h80;
    interrupt_enable_register = 8'h80;
    cyc(1);
    chk("dual wake", mode, 11'h008);
    {irq_latch, interrupt_enable_register} = 16'h0000;
    for (k = 0; k < 3; k++) begin
      pulse(stop_req);
      chk("stop", {mode[9], fast_osc_run, cpu_clk_en}, 3'h4);
      chk("stop pins", low_pins_are_port, 1'b0);
      {stop_pin_release, key_wakeup_release, voltage_det_release} = 3'h4 >> k;
      cyc(1);
      {stop_pin_release, key_wakeup_release, voltage_det_release} = 3'h0;
      for (i = 0; i < 300 && mode === 11'h400; i++) cyc(1);
      chk("warm len", i >= 128 && i < 136, 1'b1);
      chk("resume", {mode, resume_next_insn}, {11'h008, 1'b1});
    end
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule : omc_operating_mode_controller_tb
